/* rtl/bcf_framer.sv */
// burst-cut area framer, deframer and record checker behind an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bcf_defs.svh"

// ============================================================
module bcf_framer
    import bcf_pkg::*;
#(
    parameter int BUF_WORDS = 48,
    parameter int MAX_N = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [11:0] tx_word,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [11:0] rx_word,
    output logic busy
);

    localparam logic [3:0] N_MAX = 4'(MAX_N);
    localparam logic [5:0] LAST_W = 6'(BUF_WORDS - 1);

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `BCF_EDC_POLY : 32'h0000_0000);
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) r[8*k +: 8] = n[8*k +: 8];
        end
        return r;
    endfunction

    logic [31:0] buf_mem [BUF_WORDS];
    logic [31:0] ecc [4];
    logic [11:0] ctrl;
    logic [5:0] buf_idx;
    logic start_q, was_busy;
    logic done, prm_err, len_err, ord_err, ovf_err, sync_err, seq_err, edc_err;
    logic [7:0] cnt_auth, cnt_note;
    bcf_state_t state;
    logic [5:0] row;
    logic [2:0] col;
    logic [7:0] ptr, pad_at;
    logic [15:0] last_id;
    logic first_rec;
    logic [3:0] recs_left;
    logic [31:0] crc;
    logic aw_hold, w_hold;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;

    logic rx_mode, chk_only, prm_ok;
    logic [3:0] n_rows, rec_cnt;
    assign rx_mode = ctrl[`BCF_CTRL_RX];
    assign chk_only = ctrl[`BCF_CTRL_CHECK];
    assign n_rows = ctrl[`BCF_CTRL_N_LSB +: 4];
    assign rec_cnt = ctrl[`BCF_CTRL_CNT_LSB +: 4];
    assign prm_ok = (n_rows != 4'h0) && (n_rows <= N_MAX);
    assign busy = (state != ST_IDLE);

    // ============================================================
    // frame position decode
    logic [7:0] info_len, bi, ek;
    logic [5:0] four_n, row_m1, er6;
    logic is_pre, is_data, is_ecc, is_post, is_last, is_sym, is_info;
    logic [3:0] code;
    logic [7:0] exp_b, edc_b, buf_b;
    logic [11:0] cur_word;
    assign info_len = {n_rows, 4'h0} - 8'h04;
    assign four_n = {n_rows, 2'b00};
    assign row_m1 = row - 6'h01;
    assign er6 = row - four_n - 6'h01;
    assign bi = {row_m1, 2'b00} + {5'h00, col} - 8'h01;
    assign ek = bi - info_len;
    assign is_pre = (row == 6'h00);
    assign is_data = !is_pre && (row <= four_n);
    assign is_ecc = (row > four_n) && (row <= four_n + 6'h04);
    assign is_post = (row == four_n + 6'h05);
    assign is_last = (row == four_n + 6'h06);
    assign is_sym = (col == 3'h0);
    assign is_info = is_data && (bi < info_len);
    assign buf_b = buf_mem[bi[7:2]][{bi[1:0], 3'b000} +: 8];
    assign edc_b = crc[{~ek[1:0], 3'b000} +: 8];

    always_comb begin
        code = `BCF_END_CODE;
        if (is_pre) code = `BCF_SYNC_CODE;
        else if (is_data) code = row_m1[5:2] + 4'h1;
        else if (is_ecc) code = `BCF_ECC_CODE;
        else if (is_post) code = `BCF_POST_CODE;
        exp_b = `BCF_LEAD_BYTE;
        if (is_info) exp_b = (bi >= pad_at) ? 8'h00 : buf_b;
        else if (is_data) exp_b = edc_b;
        else if (is_ecc) exp_b = ecc[er6[1:0]][{bi[1:0], 3'b000} +: 8];
        else if (is_post) exp_b = `BCF_TAIL_BYTE;
        cur_word = is_sym ? {`BCF_FIXED, code} : {4'h0, exp_b};
    end

    // ============================================================
    // record walk
    logic [31:0] hw;
    logic [15:0] pid;
    logic [7:0] plen;
    logic [8:0] pnext;
    logic p_room, p_end, p_badlen, p_ovf, p_ord, p_ok;
    assign hw = buf_mem[ptr[7:2]];
    assign pid = {hw[7:0], hw[15:8]};
    assign plen = hw[31:24];
    assign pnext = {1'b0, ptr} + 9'h004 + {1'b0, plen};
    assign p_room = ({1'b0, ptr} + 9'h004) <= {1'b0, info_len};
    // without a record count, an all-zero header marks the start of the padding
    assign p_end = (rec_cnt != 4'h0) ? (recs_left == 4'h0) : (!p_room || hw == 32'h0000_0000);
    assign p_badlen = (plen == 8'h00) || (plen[1:0] != 2'b00);
    assign p_ovf = !p_room || (pnext > {1'b0, info_len});
    // strict ascent also rules out a repeated identifier; version is not looked at
    assign p_ord = !first_rec && (pid <= last_id);
    assign p_ok = (state == ST_PARSE) && !p_end && !p_badlen && !p_ovf && !p_ord;

    // ============================================================
    // channel handshakes
    logic tx_step, rx_take, rx_hunt, rx_fix, adv;
    assign tx_step = (state == ST_RUN) && !rx_mode && (!tx_valid || tx_ready);
    assign rx_ready = (state == ST_RUN) && rx_mode;
    assign rx_take = rx_ready && rx_valid;
    assign rx_hunt = is_pre && is_sym;
    assign rx_fix = (rx_word[11:4] == `BCF_FIXED);
    // while hunting, words are dropped until a frame sync is recognised
    assign adv = tx_step || (rx_take && !(rx_hunt && rx_word != cur_word));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid <= 1'b0;
            tx_word <= 12'h000;
        end else if (tx_step && !is_last) begin
            tx_valid <= 1'b1;
            tx_word <= cur_word;
        end else if (tx_step) begin
            tx_valid <= 1'b1;
            tx_word <= cur_word;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // ============================================================
    // sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            row <= 6'h00;
            col <= 3'h0;
            ptr <= 8'h00;
            pad_at <= 8'h00;
            last_id <= 16'h0000;
            first_rec <= 1'b1;
            recs_left <= 4'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_q && prm_ok) begin
                        row <= 6'h00;
                        col <= 3'h0;
                        ptr <= 8'h00;
                        first_rec <= 1'b1;
                        recs_left <= rec_cnt;
                        pad_at <= info_len;
                        state <= (rx_mode && !chk_only) ? ST_RUN : ST_PARSE;
                    end
                end
                ST_PARSE: begin
                    if (p_end) begin
                        pad_at <= ptr;
                        state <= (!rx_mode && !chk_only) ? ST_RUN : ST_IDLE;
                    end else if (!p_ok) begin
                        state <= ST_IDLE;
                    end else begin
                        ptr <= pnext[7:0];
                        last_id <= pid;
                        first_rec <= 1'b0;
                        recs_left <= recs_left - 4'h1;
                    end
                end
                ST_RUN: begin
                    if (adv) begin
                        if (is_last) begin
                            state <= rx_mode ? ST_PARSE : ST_IDLE;
                        end else if (col == 3'h4) begin
                            col <= 3'h0;
                            row <= row + 6'h01;
                        end else begin
                            col <= col + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ============================================================
    // detect check code over the information bytes, sent or received
    always_ff @(posedge aclk) begin
        if (!aresetn || start_q) begin
            crc <= 32'h0000_0000;
        end else if (adv && is_info && !is_sym) begin
            crc <= crc_byte(crc, rx_mode ? rx_word[7:0] : exp_b);
        end
    end

    // ============================================================
    // status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {done, prm_err, len_err, ord_err, ovf_err, sync_err, seq_err, edc_err} <= 8'h00;
            cnt_auth <= 8'h00;
            cnt_note <= 8'h00;
            was_busy <= 1'b0;
        end else begin
            was_busy <= busy;
            if (start_q) begin
                {done, len_err, ord_err, ovf_err, sync_err, seq_err, edc_err} <= 7'h00;
                prm_err <= !prm_ok;
                cnt_auth <= 8'h00;
                cnt_note <= 8'h00;
            end else begin
                if (was_busy && !busy) done <= 1'b1;
                if (state == ST_PARSE && !p_end) begin
                    if (p_badlen) len_err <= 1'b1;
                    if (p_ovf) ovf_err <= 1'b1;
                    if (p_ord) ord_err <= 1'b1;
                end
                if (p_ok && pid[15]) cnt_note <= cnt_note + 8'h01;
                if (p_ok && !pid[15]) cnt_auth <= cnt_auth + 8'h01;
                if (rx_take && !rx_hunt) begin
                    if (is_sym != rx_fix) sync_err <= 1'b1;
                    if (is_sym && rx_fix && rx_word[3:0] != code) seq_err <= 1'b1;
                    if (!is_sym && !is_info && !is_ecc && !(is_data && !is_info)
                        && rx_word != cur_word) seq_err <= 1'b1;
                    if (!is_sym && is_data && !is_info && rx_word[7:0] != edc_b) begin
                        edc_err <= 1'b1;
                    end
                end
            end
        end
    end

    // ============================================================
    // AXI4-Lite write side
    logic do_wr, wr_buf, rd_buf, ar_hs;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
    assign wr_buf = do_wr && (aw_q == `BCF_BDAT_OFS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q[1:0] == 2'b00 && aw_q <= `BCF_EDC_OFS)
                    ? `BCF_RESP_OKAY : `BCF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `BCF_CTRL_RST;
            start_q <= 1'b0;
        end else begin
            start_q <= do_wr && aw_q == `BCF_CTRL_OFS && ws_q[0] && wd_q[`BCF_CTRL_START]
                && !busy && !tx_valid;
            if (do_wr && aw_q == `BCF_CTRL_OFS && !busy) begin
                ctrl <= 12'(merge({20'h0_0000, ctrl}, wd_q, ws_q) & 32'h0000_0FF6);
            end
        end
    end

    // received information bytes land in the same buffer the walker reads
    always_ff @(posedge aclk) begin
        if (wr_buf && !busy && buf_idx <= LAST_W) begin
            buf_mem[buf_idx] <= merge(buf_mem[buf_idx], wd_q, ws_q);
        end else if (rx_take && adv && is_info && !is_sym) begin
            buf_mem[bi[7:2]][{bi[1:0], 3'b000} +: 8] <= rx_word[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int j = 0; j < 4; j++) ecc[j] <= 32'h0000_0000;
        end else if (do_wr && aw_q[7:4] == 4'h1 && aw_q[1:0] == 2'b00 && !busy) begin
            ecc[aw_q[3:2]] <= merge(ecc[aw_q[3:2]], wd_q, ws_q);
        end else if (rx_take && is_ecc && !is_sym) begin
            ecc[er6[1:0]][{bi[1:0], 3'b000} +: 8] <= rx_word[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_idx <= 6'h00;
        end else if (do_wr && aw_q == `BCF_BIDX_OFS && ws_q[0]) begin
            buf_idx <= wd_q[5:0];
        end else begin
            // data port walks the buffer so software can stream words
            buf_idx <= buf_idx + {5'h00, wr_buf} + {5'h00, rd_buf};
        end
    end

    // ============================================================
    // AXI4-Lite read side
    logic [31:0] rd_mux;
    logic rd_ok;
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_buf = ar_hs && (s_axi_araddr == `BCF_BDAT_OFS) && !wr_buf;

    always_comb begin
        rd_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            `BCF_CTRL_OFS: rd_mux = {20'h0_0000, ctrl};
            `BCF_STAT_OFS: rd_mux = {cnt_note, cnt_auth, 7'h00, edc_err, seq_err, sync_err,
                                     ovf_err, ord_err, len_err, prm_err, done, busy};
            `BCF_BIDX_OFS: rd_mux = {26'h000_0000, buf_idx};
            `BCF_BDAT_OFS: rd_mux = (buf_idx <= LAST_W) ? buf_mem[buf_idx] : 32'h0000_0000;
            8'h10, 8'h14, 8'h18, `BCF_ECC3_OFS: rd_mux = ecc[s_axi_araddr[3:2]];
            `BCF_EDC_OFS: rd_mux = crc;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BCF_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `BCF_RESP_OKAY : `BCF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // bcf_framer
`default_nettype wire

/* rtl/bcf_defs.svh */
// register map, field positions and symbol constants of the burst-cut area framer
`ifndef BCF_DEFS_SVH
`define BCF_DEFS_SVH

// ============================================================
// register byte offsets
`define BCF_CTRL_OFS 8'h00
`define BCF_STAT_OFS 8'h04
`define BCF_BIDX_OFS 8'h08
`define BCF_BDAT_OFS 8'h0C
`define BCF_ECC0_OFS 8'h10
`define BCF_ECC3_OFS 8'h1C
`define BCF_EDC_OFS 8'h20

// ============================================================
// control fields
`define BCF_CTRL_START 0
`define BCF_CTRL_RX 1
`define BCF_CTRL_CHECK 2
`define BCF_CTRL_N_LSB 4
`define BCF_CTRL_CNT_LSB 8
`define BCF_CTRL_RST 12'h000

// ============================================================
// symbol and field content
`define BCF_FIXED 8'h46
`define BCF_SYNC_CODE 4'h0
`define BCF_ECC_CODE 4'hD
`define BCF_POST_CODE 4'hE
`define BCF_END_CODE 4'hF
`define BCF_LEAD_BYTE 8'h00
`define BCF_TAIL_BYTE 8'h55
`define BCF_EDC_POLY 32'h8000_0011

// ============================================================
// bus answers
`define BCF_RESP_OKAY 2'h0
`define BCF_RESP_SLVERR 2'h2

`endif

/* rtl/bcf_pkg.sv */
// types shared by the burst-cut area framer
package bcf_pkg;

    // ============================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PARSE,
        ST_RUN
    } bcf_state_t;

endpackage

/* dv/bcf_framer_sva.sv */
// checker of the framer's port behaviour
`timescale 1ns/1ns
`default_nettype none
`include "bcf_defs.svh"
module bcf_framer_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [11:0] tx_word,
    input wire logic rx_ready,
    input wire logic busy
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic hs;
    logic sym;
    logic [3:0] last;
    assign hs = tx_valid && tx_ready;
    assign sym = tx_word[11:4] == `BCF_FIXED;
    // ==========================================
    // last accepted symbol code, so row numbering can be followed across words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last <= 4'h0;
        end else if (hs && sym) begin
            last <= tx_word[3:0];
        end
    end
    // ==========================================
    // assertions
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
        else $error("tx word changed before accept");
    AST_FIRST_SYNC: assert property ($rose(tx_valid) |-> tx_word == 12'h460)
        else $error("frame does not open with sync");
    AST_LEAD_PAD: assert property (hs && tx_word == 12'h460 |=> tx_word == 12'h000)
        else $error("lead pad missing after sync");
    AST_FIXED: assert property (tx_valid && tx_word[11:8] != 4'h0 |-> sym)
        else $error("symbol without fixed part");
    AST_ROW_ORDER: assert property (hs && sym && tx_word[3:0] inside {[1:12]}
        |-> tx_word[3:0] == last || tx_word[3:0] == last + 4'h1)
        else $error("resync numbering skipped");
    AST_TAIL_ORDER: assert property (hs && sym && tx_word[3:0] > 4'hD
        |-> last == tx_word[3:0] - 4'h1)
        else $error("tail resync out of order");
    AST_TAIL_PAD: assert property (hs && tx_word == 12'h46E |=> tx_word == 12'h055)
        else $error("tail pad missing");
    AST_RX_READY: assert property (rx_ready |-> busy && !tx_valid)
        else $error("rx ready while idle");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    cover property (hs && tx_word == 12'h46F);
    cover property (rx_ready);
    cover property (s_axi_bvalid && s_axi_bresp == `BCF_RESP_SLVERR);
endmodule // bcf_framer_sva
bind bcf_framer bcf_framer_sva chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bresp, .tx_valid, .tx_ready, .tx_word, .rx_ready,
    .busy);
`default_nettype wire

/* dv/bcf_chan_model.sv */
// channel-side model: takes framed words with stalls, replays words into the deframer
`timescale 1ns/1ns
`default_nettype none
module bcf_chan_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [11:0] tx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [11:0] rx_word
);
    logic [11:0] txq[$];
    logic [11:0] rxq[$];
    logic [1:0] cnt;
    // ==========================================
    // ready drops one cycle in three so the framer must hold its word
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_word <= 12'h000;
            cnt <= 2'd0;
        end else begin
            cnt <= (cnt == 2'd2) ? 2'd0 : cnt + 2'd1;
            tx_ready <= cnt != 2'd0;
            if (tx_valid && tx_ready) begin
                txq.push_back(tx_word);
            end
            if (rx_valid && rx_ready && rxq.size() > 0) begin
                void'(rxq.pop_front());
            end
            rx_valid <= rxq.size() > 0;
            // an idle line shows the inverse, never a stale copy
            rx_word <= (rxq.size() > 0) ? rxq[0] : ~rx_word;
        end
    end
endmodule // bcf_chan_model
`default_nettype wire

/* dv/bcf_framer_test.sv */
// self-checking bench of the burst-cut area framer
`timescale 1ns/1ns
`default_nettype none
`include "bcf_defs.svh"
module bcf_framer_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    logic tx_valid, tx_ready, rx_valid, rx_ready, busy;
    logic [11:0] tx_word, rx_word;
    logic [11:0] ex[$];
    logic [11:0] frame[$];
    int num_errors = 0;
    int tests_run = 0;
    always #50 aclk = ~aclk;
    bcf_framer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_ready, .tx_word,
        .rx_valid, .rx_ready, .rx_word, .busy);
    bcf_chan_model chan_u (.aclk, .aresetn, .tx_valid, .tx_ready, .tx_word, .rx_valid,
        .rx_ready, .rx_word);
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // the leading edge keeps a release and the next raise out of one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        @(posedge aclk);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
            if (aw) begin
                s_axi_awvalid <= 1'b0;
            end
            if (w) begin
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_done;
        // a refused n never starts the sequencer, so done stays low and only bad n shows
        do rd(`BCF_STAT_OFS); while (rdat[1] !== 1'b1 && rdat[2] !== 1'b1);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        rd(`BCF_CTRL_OFS);
        check(rdat, 32'h0000_0000);
        rd(`BCF_STAT_OFS);
        check(rdat, 32'h0000_0000);
        rd(8'h24);
        check({rdat[29:0], resp}, {30'h0, `BCF_RESP_SLVERR});
        wr(8'h40, 32'h0000_0001);
        check({30'h0, resp}, {30'h0, `BCF_RESP_SLVERR});
        $display("register test done");
    endtask
    task automatic t_walk;
        logic [31:0] w0[6] = '{32'h0400_0100, 32'h0400_0590, 32'h0600_0100, 32'h0000_0100,
            32'h1C00_0100, 32'h0400_0100};
        logic [31:0] mk[6] = '{32'hFFFF_01FE, 32'h0000_01FC, 32'h0000_01FC, 32'h0000_01FC,
            32'h0000_01FC, 32'h0000_01FC};
        logic [31:0] ev[6] = '{32'h0101_0002, 32'h0000_0010, 32'h0000_0008, 32'h0000_0008,
            32'h0000_0020, 32'h0000_0004};
        logic [3:0] n[6] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'hD};
        int c;
        int j;
        for (c = 0; c < 6; c++) begin
            wr(`BCF_BIDX_OFS, 32'h0000_0000);
            for (j = 0; j < 7; j++) begin
                wr(`BCF_BDAT_OFS, (j == 0) ? w0[c] : (j == 2 && c < 2) ? w0[c] + 32'h0180 :
                    32'h0000_0000);
            end
            wr(`BCF_CTRL_OFS, {24'h00_0000, n[c], 4'h5});
            wait_done;
            check(rdat & mk[c], ev[c]);
        end
        $display("record walk test done");
    endtask
    task automatic t_frame;
        logic [7:0] ib[16] = '{8'h80, 8'h01, 8'h03, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [31:0] crc = 32'h0000_0000;
        logic [31:0] e;
        logic fb;
        int k;
        int r;
        for (k = 0; k < 96; k++) begin
            fb = crc[31] ^ ib[k / 8][7 - k % 8];
            crc = {crc[30:0], 1'b0} ^ (fb ? `BCF_EDC_POLY : 32'h0000_0000);
        end
        {ib[12], ib[13], ib[14], ib[15]} = crc;
        wr(`BCF_BIDX_OFS, 32'h0000_0000);
        wr(`BCF_BDAT_OFS, 32'h0403_0180);
        wr(`BCF_BDAT_OFS, 32'h4433_2211);
        // garbage past the single record must leave as zeros
        wr(`BCF_BDAT_OFS, 32'hDEAD_BEEF);
        for (r = 0; r < 4; r++) begin
            wr(`BCF_ECC0_OFS + 8'(4 * r), 32'hA0B0_C0D0 + 32'(r));
        end
        wr(`BCF_CTRL_OFS, 32'h0000_0111);
        do @(posedge aclk); while (chan_u.txq.size() < 51);
        wait_done;
        check(rdat, 32'h0100_0002);
        ex = {12'h460, 12'h000, 12'h000, 12'h000, 12'h000};
        for (r = 0; r < 8; r++) begin
            e = 32'hA0B0_C0D0 + 32'(r - 4);
            ex.push_back((r < 4) ? 12'h461 : 12'h46D);
            for (k = 0; k < 4; k++) begin
                ex.push_back({4'h0, (r < 4) ? ib[4 * r + k] : e[8 * k +: 8]});
            end
        end
        ex = {ex, 12'h46E, 12'h055, 12'h055, 12'h055, 12'h055, 12'h46F};
        check(32'(chan_u.txq.size()), 32'h0000_0033);
        for (k = 0; k < 51; k++) begin
            check({20'h0, chan_u.txq[k]}, {20'h0, ex[k]});
        end
        frame = chan_u.txq;
        $display("framing test done");
    endtask
    task automatic t_rx;
        int idx[4] = '{5, 21, 6, -1};
        logic [11:0] val[4];
        logic [31:0] ev[4] = '{32'h0000_0080, 32'h0000_0100, 32'h0000_0040, 32'h0100_0002};
        logic [31:0] mk[4] = '{32'h0000_0080, 32'h0000_0100, 32'h0000_0040, 32'hFFFF_01FE};
        int c;
        val = '{12'h462, frame[21] ^ 12'h001, 12'h461, 12'h000};
        for (c = 0; c < 4; c++) begin
            // a stray byte ahead of the sync must be hunted past
            chan_u.rxq = {12'h0A5, frame};
            if (idx[c] >= 0) begin
                chan_u.rxq[idx[c] + 1] = val[c];
            end
            wr(`BCF_CTRL_OFS, 32'h0000_0113);
            wait_done;
            check(rdat & mk[c], ev[c]);
            chan_u.rxq.delete();
        end
        wr(`BCF_BIDX_OFS, 32'h0000_0002);
        rd(`BCF_BDAT_OFS);
        check(rdat, 32'h0000_0000);
        $display("read-back test done");
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        $display("watchdog expired");
        test_done;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_walk;
        t_frame;
        t_rx;
        test_done;
    end
endmodule // bcf_framer_test
`default_nettype wire
